// ==== rtl/adc_link_pkg.sv ====
// shared constants, types and code tables for the sample link encoder
package adc_link_pkg;

    // converter sample and lane widths
    localparam int SAMPLE_W = 14;
    localparam int OCTET_W  = 8;
    localparam int CODE_W   = 10;
    localparam int SCR_W    = 15;    // scrambler history, one plus x14 plus x15
    localparam int SCR_TAPA = 13;    // 14 bits back
    localparam int SCR_TAPB = 14;    // 15 bits back

    // control characters, as octets
    localparam logic [7:0] K28_1 = 8'h3c;
    localparam logic [7:0] K28_5 = 8'hbc;
    localparam logic [7:0] K28_7 = 8'hfc;
    localparam logic [7:0] FAM_SCR_MARK = 8'h7c;

    // code-group sub-block constants (abcdei / fghj, a transmitted first)
    localparam logic [5:0] K28_SIX   = 6'h0f;
    localparam logic [3:0] ALT7_FOUR = 4'h7;
    localparam logic [2:0] SIX_BAL   = 3'h3;
    localparam logic [2:0] FOUR_BAL  = 3'h2;

    // 5b/6b codes for negative disparity, index is the five-bit value x
    localparam logic [5:0] SIX_TABLE [32] = '{
        6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
        6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};

    // 3b/4b codes for negative disparity, index is the three-bit value y
    localparam logic [3:0] FOUR_TABLE [8] = '{
        4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

    // reset values
    localparam logic       RD_RESET    = 1'b0;   // 0 means negative
    localparam logic [14:0] SCR_RESET  = 15'h0000;
    localparam logic [1:0] RST_SYNC_INIT = 2'h0;

    // subclass selection
    typedef enum logic [1:0] {
        SUBCLASS0 = 2'h0,
        SUBCLASS1 = 2'h1,
        SUBCLASS2 = 2'h2
    } subclass_e;

    // link state, gray coded
    typedef enum logic [1:0] {
        LINK_COMMA = 2'b00,
        LINK_DATA  = 2'b01
    } link_e;

    // one captured sample
    typedef struct packed {
        logic [SAMPLE_W-1:0] code;
        logic                over;
    } sample_s;

    // one octet with its control flag
    typedef struct packed {
        logic       k;
        logic [7:0] d;
    } octet_s;

endpackage

// ==== rtl/serial_adc_link_encoder.sv ====
// sample timing, scrambling, 8b/10b framing for one serial output lane
// Operation
// R1 - divide-by-one samples on falling clock edge
// R2 - divide-by-two samples once per two periods
// R3 - divider init fixes the sampling period
// R4 - subclass 1: sysref rise initializes divider
// R5 - subclass 2: sync rise initializes divider
// R6 - octets map to standard 8b/10b code-groups
// R7 - running disparity picks balanced code alternative
// R8 - data codes named Dx.y, five/three split
// R9 - twelve Kx.y control codes distinct from data
// R10 - comma is 0011111 or 1100000 prefix
// R11 - only K28.1, K28.5, K28.7 carry commas
// R12 - optional scrambler uses one plus x14 x15
// R13 - receiver descrambler self-aligns, loses fifteen bits
// R14 - frame is two code-groups, one sample
// R15 - latency repeatable after every sync event
// R16 - sync low sends K28.5 continuously
// R17 - K28.7 replaces last frame octet when due
// R18 - disparity judged on six then four bits
// R19 - scrambler acts on octets before encoding
// R20 - disparity starts negative, updates per code-group
`timescale 1ns/1ns
module serial_adc_link_encoder
    import adc_link_pkg::*;
#(
    parameter int SAMPLE_BITS = SAMPLE_W
) (
    input  wire logic                   mclk,
    input  wire logic                   resetn,
    input  wire logic                   divByTwo,
    input  wire logic [1:0]             subclass,
    input  wire logic                   scramblerOn,
    input  wire logic                   famEnable,
    input  wire logic                   sysref,
    input  wire logic                   syncN,
    input  wire logic [SAMPLE_BITS-1:0] sampleIn,
    input  wire logic                   sampleOver,
    output logic                        sampleOnFall,
    output logic                        sampleTake,
    output logic                        sampleLost,
    output logic [2*CODE_W-1:0]         frameOut,
    output logic                        frameValid,
    input  wire logic                   frameReady,
    output logic                        linkData
);

    ////////////////////////////////////////////////////////////////////////
    // overview of the lane path
    //   sampler -> two-entry buffer -> scrambler -> encoder -> lane register
    // the buffer absorbs a short receiver stall; a longer one drops samples
    //   and flags each drop on sampleLost rather than stalling the sampler
    // scrambler and both encoders form one combinational cone in front of
    //   the lane register, traded against a deeper pipeline and more area
    // disparity chains from the first code-group into the second within
    //   one cycle, so the register always holds a consistent pair
    // control frames bypass the scrambler and leave its history alone,
    //   so the far side keeps its lock across a burst of commas
    // only K28 control characters are built; other Kx.y are never sent
    // the divider state is a single phase flop; in subclass 0 it free-runs
    //   from the reset release and no sync input moves it
    // a rising edge on the selected sync input restarts the divider at
    //   that same edge, which keeps the latency equal after each event
    // sampleOnFall tells the analog front end which edge holds the input
    //   in divide-by-one mode; the logic here still runs on rising edges
    // the alignment marker compares with the previous frame's last octet
    //   when scrambling is off, and with one fixed octet when it is on
    // the overflow flag travels in bit one of the second octet

    ////////////////////////////////////////////////////////////////////////
    // 8b/10b encoder: returns {new disparity, abcdei fghj}
    function automatic logic [CODE_W:0] encode(input octet_s o,
                                               input logic   rdIn);
        logic [4:0] x;
        logic [2:0] y;
        logic [5:0] six;
        logic [3:0] four;
        logic       unb6;
        logic       unb4;
        logic       rd6;
        logic       alt;
        logic       comp4;
        x    = o.d[4:0];
        y    = o.d[7:5];
        six  = o.k ? K28_SIX : SIX_TABLE[x];                // see R8 see R9
        unb6 = ($countones(six) != 32'(SIX_BAL));          // see R18
        if (rdIn && (unb6 || (!o.k && x == 5'h07))) begin
            six = ~six;                                     // see R7
        end
        rd6  = unb6 ? ~rdIn : rdIn;
        // alternate D.x.7 avoids a run of five; K28.7 always uses it
        alt  = (y == 3'h7) && (o.k ||
               (!rd6 && (x == 5'd17 || x == 5'd18 || x == 5'd20)) ||
               (rd6 && (x == 5'd11 || x == 5'd13 || x == 5'd14))); // see R10
        four = alt ? ALT7_FOUR : FOUR_TABLE[y];
        unb4 = ($countones(four) != 32'(FOUR_BAL));        // see R18
        comp4 = (unb4 || y == 3'h3) ? rd6 : (o.k && rdIn); // see R7
        four = comp4 ? ~four : four;
        return {unb4 ? ~rd6 : rd6, six, four};              // see R6 see R20
    endfunction

    // self-synchronizing scrambler over one frame, msb first
    function automatic logic [SCR_W+15:0] scramble(input logic [15:0] d,
                                                   input logic [14:0] st);
        logic [15:0] s;
        logic        b;
        s = 16'h0000;
        for (int i = 15; i >= 0; i--) begin
            b    = d[i] ^ st[SCR_TAPA] ^ st[SCR_TAPB];      // see R12
            s[i] = b;
            st   = {st[13:0], b};
        end
        return {st, s};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset release through two flip-flops
    logic [1:0] rstSync;
    logic       rstn;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rstSync <= RST_SYNC_INIT;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstn = rstSync[1];

    ////////////////////////////////////////////////////////////////////////
    // divider initialization events
    logic sysrefPrev;
    logic syncPrev;
    logic initEvent;
    logic phase;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sysrefPrev <= 1'b0;
            // idle level of the sync input, so release shows no false rise
            syncPrev   <= 1'b1;
        end else begin
            sysrefPrev <= sysref;
            syncPrev   <= syncN;
        end
    end

    // a rising edge seen at this clock edge makes this edge the sample
    assign initEvent =
        (subclass == SUBCLASS1 && sysref && !sysrefPrev) ||  // see R4
        (subclass == SUBCLASS2 && syncN && !syncPrev);       // see R5

    // divide-by-one holds on the falling edge; the front end uses this
    assign sampleOnFall = !divByTwo;                          // see R1
    assign sampleTake   = divByTwo ? (initEvent || phase) : 1'b1; // see R2

    // phase alternates in divide-by-two mode and stays low in divide-by-one; an init event pins it so latency repeats
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            phase <= 1'b0;
        end else begin
            phase <= !sampleTake;                             // see R3 see R15
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two-entry buffer between sampler and encoder
    sample_s bufMem [2];
    logic    wrPtr;
    logic    rdPtr;
    logic [1:0] fill;
    logic    bufValid;
    logic    bufReady;
    logic    bufPop;
    logic    bufPush;
    sample_s head;

    assign bufReady   = (fill != 2'h2);
    assign bufValid   = (fill != 2'h0);
    assign bufPush    = sampleTake && bufReady;
    assign sampleLost = sampleTake && !bufReady;  // stall longer than buffer
    assign head       = bufMem[rdPtr];

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wrPtr <= 1'b0;
            rdPtr <= 1'b0;
            fill  <= 2'h0;
        end else begin
            wrPtr <= wrPtr ^ bufPush;
            rdPtr <= rdPtr ^ bufPop;
            fill  <= fill + {1'b0, bufPush} - {1'b0, bufPop};
        end
    end

    // storage needs no reset; fill guards every read
    always_ff @(posedge mclk) begin
        if (bufPush) begin
            bufMem[wrPtr] <= '{code: sampleIn[SAMPLE_BITS-1 -: SAMPLE_W],
                             over: sampleOver};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link state follows the receiver's sync request
    link_e state;
    link_e next_state;
    logic  outFree;

    assign outFree = !frameValid || frameReady;

    always_comb begin
        case (state)
            LINK_COMMA: next_state = syncN ? LINK_DATA : LINK_COMMA;
            LINK_DATA:  next_state = syncN ? LINK_DATA : LINK_COMMA;
            default:    next_state = LINK_COMMA;
        endcase
    end

    // state advances only between frames so a frame is never split
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state <= LINK_COMMA;
        end else if (outFree) begin
            state <= next_state;
        end
    end
    assign linkData = (state == LINK_DATA);

    ////////////////////////////////////////////////////////////////////////
    // frame assembly: two octets per sample, scrambled then encoded
    logic [15:0]     rawFrame;
    logic [SCR_W+15:0] scrOut;
    logic [15:0]     octets;
    logic            famHit;
    octet_s          first;
    octet_s          last;
    logic [CODE_W:0] enc0;
    logic [CODE_W:0] enc1;
    logic            rd;
    logic [14:0]     scrState;
    logic [7:0]      prevLast;
    logic            sendData;

    // in comma state the buffer drains so stale samples never leak out
    assign sendData = (state == LINK_DATA) && bufValid;
    assign bufPop   = bufValid && outFree;

    assign rawFrame = {head.code, head.over, 1'b0};           // see R14
    assign scrOut   = scramble(rawFrame, scrState);           // see R19
    assign octets   = scramblerOn ? scrOut[15:0] : rawFrame;

    // frame alignment marker on the final octet
    assign famHit = famEnable && (scramblerOn ?
                    (octets[7:0] == FAM_SCR_MARK) :
                    (octets[7:0] == prevLast));               // see R17

    always_comb begin
        if (state == LINK_COMMA) begin
            first = '{k: 1'b1, d: K28_5};                     // see R16
            last  = '{k: 1'b1, d: K28_5};                     // see R11
        end else begin
            first = '{k: 1'b0, d: octets[15:8]};
            last  = famHit ? '{k: 1'b1, d: K28_7} :
                             '{k: 1'b0, d: octets[7:0]};
        end
    end

    // disparity chains through both code-groups of the frame
    assign enc0 = encode(first, rd);
    assign enc1 = encode(last, enc0[CODE_W]);

    // running disparity and scrambler history
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rd       <= RD_RESET;                             // see R20
            scrState <= SCR_RESET;
            prevLast <= 8'h00;
        end else if (outFree && (state == LINK_COMMA || bufValid)) begin
            rd <= enc1[CODE_W];                               // see R7
            if (sendData) begin
                scrState <= scramblerOn ? scrOut[SCR_W+15:16] : scrState;
                prevLast <= octets[7:0];
            end
        end
    end

    // output lane register, first code-group in the upper bits
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            frameOut   <= '0;
            frameValid <= 1'b0;
        end else if (outFree) begin
            frameValid <= (state == LINK_COMMA) || bufValid;
            if ((state == LINK_COMMA) || bufValid) begin
                frameOut <= {enc0[CODE_W-1:0], enc1[CODE_W-1:0]}; // see R6
            end
        end
    end

endmodule // serial_adc_link_encoder

// ==== dv/link_encoder_assertions.sv ====
// port-level checks on the sample link encoder
`timescale 1ns/1ns
module link_encoder_assertions
    import adc_link_pkg::*;
#(
    parameter int SAMPLE_BITS = SAMPLE_W
) (
    input wire logic                   mclk,
    input wire logic                   resetn,
    input wire logic                   divByTwo,
    input wire logic [1:0]             subclass,
    input wire logic                   scramblerOn,
    input wire logic                   famEnable,
    input wire logic                   sysref,
    input wire logic                   syncN,
    input wire logic [SAMPLE_BITS-1:0] sampleIn,
    input wire logic                   sampleOver,
    input wire logic                   sampleOnFall,
    input wire logic                   sampleTake,
    input wire logic                   sampleLost,
    input wire logic [2*CODE_W-1:0]    frameOut,
    input wire logic                   frameValid,
    input wire logic                   frameReady,
    input wire logic                   linkData
);
    localparam logic [19:0] CPN = 20'h3eb05;
    localparam logic [19:0] CPP = 20'hc14fa;
    logic [1:0] rq;
    logic       live;
    // mirror the internal reset release so checks start with the logic
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) rq <= 2'h0;
        else rq <= {rq[0], 1'b1};
    end
    assign live = rq[1];

    sample_edge_a: assert property (@(posedge mclk) disable iff (!live)
        sampleOnFall == !divByTwo) else $error("sampling edge wrong");
    every_edge_a: assert property (@(posedge mclk) disable iff (!live)
        !divByTwo |-> sampleTake) else $error("div1 sample skipped");
    half_skip_a: assert property (@(posedge mclk) disable iff (!live)
        divByTwo && sampleTake |=> !divByTwo || !sampleTake
        || (subclass == 2'h1 && $rose(sysref))
        || (subclass == 2'h2 && $rose(syncN))) else $error("div2 double");
    half_gap_a: assert property (@(posedge mclk) disable iff (!live)
        divByTwo && !sampleTake |=> !divByTwo || sampleTake)
        else $error("div2 sample missing");
    sysref_init_a: assert property (@(posedge mclk) disable iff (!live)
        divByTwo && subclass == 2'h1 && $rose(sysref)
        |-> sampleTake ##1 !sampleTake ##1 sampleTake) else $error("sysref init");
    sync_init_a: assert property (@(posedge mclk) disable iff (!live)
        divByTwo && subclass == 2'h2 && $rose(syncN)
        |-> sampleTake ##1 !sampleTake ##1 sampleTake) else $error("sync init");
    comma_send_a: assert property (@(posedge mclk) disable iff (!live)
        !syncN && (!frameValid || frameReady) |=> !linkData)
        else $error("comma state not entered");
    comma_frame_a: assert property (@(posedge mclk) disable iff (!live)
        $past(live) && $past(!linkData && (!frameValid || frameReady))
        |-> frameValid && (frameOut == CPN || frameOut == CPP))
        else $error("comma frame bad");
    stall_hold_a: assert property (@(posedge mclk) disable iff (!live)
        frameValid && !frameReady |=> frameValid && $stable(frameOut))
        else $error("frame changed in stall");
    code_balance_a: assert property (@(posedge mclk) disable iff (!live)
        frameValid |-> $countones(frameOut[19:10]) inside {4, 5, 6}
        && $countones(frameOut[9:0]) inside {4, 5, 6})
        else $error("unbalanced code-group");
endmodule // link_encoder_assertions

// ==== dv/rx_partner.sv ====
// far-side receiver: sync request and flow control
`timescale 1ns/1ns
module rx_partner (
    input  wire logic mclk,
    input  wire logic wantSync,
    input  wire logic slow,
    output logic      syncN,
    output logic      frameReady
);
    initial begin
        syncN = 1'b0;
        frameReady = 1'b1;
    end
    // changes land after the falling edge, clear of the sampling edge
    always @(negedge mclk) begin
        syncN      <= !wantSync;
        frameReady <= !slow || ($urandom % 4 == 0);
    end
endmodule // rx_partner

// ==== dv/testbench.sv ====
// self-checking bench for the sample link encoder
`timescale 1ns/1ns
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin errTotal++; \
    $display("Error at %0t: value mismatch", $time); end end
module testbench;
    import adc_link_pkg::*;
    logic mclk = 0, resetn = 0, divByTwo = 0, scramblerOn = 0, famEnable = 0;
    logic sysref = 0, sampleOver = 0, wantSync = 1, slow = 0, rd = RD_RESET;
    logic [1:0] subclass = 2'h0;
    logic [SAMPLE_W-1:0] sampleIn = '0;
    logic syncN, frameReady, sampleOnFall, sampleTake, sampleLost;
    logic frameValid, linkData, align = 0;
    logic [2*CODE_W-1:0] frameOut, expF;
    logic [SAMPLE_W:0] expQ[$];
    logic [SAMPLE_W:0] e;
    logic [15:0] got, raw;
    logic [14:0] dh;
    logic [7:0] lastOct = 8'h00;
    int errTotal = 0, nChecks = 0, cyc = 0;

    always #5 mclk = ~mclk;
    serial_adc_link_encoder dut (.mclk(mclk), .resetn(resetn),
        .divByTwo(divByTwo), .subclass(subclass), .scramblerOn(scramblerOn),
        .famEnable(famEnable), .sysref(sysref), .syncN(syncN),
        .sampleIn(sampleIn), .sampleOver(sampleOver),
        .sampleOnFall(sampleOnFall), .sampleTake(sampleTake),
        .sampleLost(sampleLost), .frameOut(frameOut), .frameValid(frameValid),
        .frameReady(frameReady), .linkData(linkData));
    rx_partner peer (.mclk(mclk), .wantSync(wantSync), .slow(slow),
        .syncN(syncN), .frameReady(frameReady));

    // reference 8b/10b: negative-disparity tables, flipped when positive
    function automatic logic [9:0] enc(input logic [7:0] o);
        logic [5:0] s;
        logic [3:0] f;
        int x;
        x = o[4:0];
        s = SIX_TABLE[x];
        f = FOUR_TABLE[o[7:5]];
        if (rd && ($countones(s) != 3 || s == 6'h38)) s = ~s;
        if ($countones(s) != 3) rd = ~rd;
        if (o[7:5] == 3'h7 && ((!rd && (x == 17 || x == 18 || x == 20))
            || (rd && (x == 11 || x == 13 || x == 14)))) f = ALT7_FOUR;
        if (rd && ($countones(f) != 2 || f == 4'hc)) f = ~f;
        if ($countones(f) != 2) rd = ~rd;
        return {s, f};
    endfunction

    // reference decode: search the octet whose code matches at this disparity
    function automatic logic [7:0] dec(input logic [9:0] cg);
        logic r0;
        r0 = rd;
        for (int o = 0; o < 256; o++) begin
            rd = r0;
            if (enc(8'(o)) == cg) return 8'(o);
        end
        rd = r0;
        // the marker leaves disparity unchanged and stands for octet 7c
        return (cg == (rd ? 10'h307 : 10'h0f8)) ? 8'h7c : 8'hxx;
    endfunction

    task automatic finalReport();
        if (errTotal == 0 && nChecks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // random samples reach the converter port every cycle
    always @(negedge mclk) begin
        // narrow low bits make the repeat marker likely in the plain mode
        sampleIn <= SAMPLE_W'($urandom)
            & (famEnable && !scramblerOn ? 14'h3fc3 : 14'h3fff);
        sampleOver <= 1'($urandom);
    end
    // note each sample the data state keeps; comma state discards them,
    // but the sample taken as the link leaves comma state is sent first
    always @(posedge mclk) begin
        if (!linkData) expQ.delete();
        if ((linkData || (syncN && (!frameValid || frameReady)))
            && sampleTake && !sampleLost)
            expQ.push_back({sampleIn, sampleOver});
    end
    // compare each accepted data frame with the oldest note
    always @(posedge mclk) begin
        if (frameValid && frameReady && frameOut !== 20'h3eb05
            && frameOut !== 20'hc14fa && (linkData || expQ.size() > 0)) begin
            e = (expQ.size() > 0) ? expQ.pop_front() : 'x;
            if (scramblerOn) begin
                got[15:8] = dec(frameOut[19:10]);
                got[7:0] = dec(frameOut[9:0]);
                // self-aligning descrambler fed only by received bits
                for (int i = 15; i >= 0; i--) begin
                    raw[i] = got[i] ^ dh[13] ^ dh[14];
                    dh = {dh[13:0], got[i]};
                end
                // the first frame only fills the history and is lost
                if (align) align = 1'b0;
                else `CHK(raw, {e, 1'b0})
            end else begin
                expF[19:10] = enc(e[14:7]);
                if (famEnable && {e[6:0], 1'b0} == lastOct)
                    expF[9:0] = rd ? 10'h307 : 10'h0f8;
                else
                    expF[9:0] = enc({e[6:0], 1'b0});
                lastOct = {e[6:0], 1'b0};
                `CHK(frameOut, expF)
            end
        end
    end
    // hang guard: the four phases need well under 1000 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 2000) begin
            errTotal++;
            finalReport();
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // one phase: reset, comma request, release, free run, stall, run
    task automatic phase(input logic d2, input logic [1:0] sc, input logic sx);
        @(negedge mclk);
        resetn = 1'b0;
        divByTwo = d2;
        subclass = sc;
        scramblerOn = sx;
        famEnable = sx || (sc == 2'h2);
        align = sx;
        lastOct = 8'h00;
        rd = RD_RESET;
        wantSync <= 1'b1;
        sysref = 1'b0;
        repeat (20) @(negedge mclk);
        resetn = 1'b1;
        repeat (8) @(negedge mclk);
        `CHK(linkData, 1'b0)
        wantSync <= 1'b0;
        repeat (6) @(negedge mclk);
        sysref = 1'b1;
        repeat (40) @(negedge mclk);
        slow <= 1'b1;
        repeat (40) @(negedge mclk);
        slow <= 1'b0;
        repeat (30) @(negedge mclk);
    endtask

    initial begin
        void'($urandom(14));
        phase(1'b0, 2'h0, 1'b0);
        phase(1'b1, 2'h1, 1'b0);
        phase(1'b1, 2'h2, 1'b0);
        phase(1'b0, 2'h0, 1'b1);
        finalReport();
    end
endmodule // testbench

bind serial_adc_link_encoder link_encoder_assertions #(
    .SAMPLE_BITS(SAMPLE_BITS)) checker_i (.mclk(mclk), .resetn(resetn),
    .divByTwo(divByTwo), .subclass(subclass), .scramblerOn(scramblerOn),
    .famEnable(famEnable), .sysref(sysref), .syncN(syncN),
    .sampleIn(sampleIn), .sampleOver(sampleOver),
    .sampleOnFall(sampleOnFall), .sampleTake(sampleTake),
    .sampleLost(sampleLost), .frameOut(frameOut), .frameValid(frameValid),
    .frameReady(frameReady), .linkData(linkData));
